//--- core/pse_irq_pkg.sv
// constants, register map and summary mapping for the interrupt aggregator
package pse_irq_pkg;

  localparam int NUM_GROUPS      = 2;
  localparam int PORTS_PER_GROUP = 4;
  localparam int NUM_PORTS       = NUM_GROUPS * PORTS_PER_GROUP;
  localparam int NUM_EVREGS      = 6;
  localparam int BYTE_W          = 8;
  localparam int NIB             = 4;
  localparam int EV_BUS_W        = NUM_GROUPS * BYTE_W;

  typedef logic [BYTE_W-1:0] byte_t;
  typedef logic [2:0]        evidx_t;
  typedef logic [NUM_EVREGS-1:0][BYTE_W-1:0] evbank_t;

  // register addresses, the same in each group's register page
  localparam byte_t ADDR_SUMMARY   = 8'h00;
  localparam byte_t ADDR_MASK      = 8'h01;
  localparam byte_t ADDR_POWER     = 8'h02;
  localparam byte_t ADDR_POWER_C   = 8'h03;
  localparam byte_t ADDR_PROBE     = 8'h04;
  localparam byte_t ADDR_PROBE_C   = 8'h05;
  localparam byte_t ADDR_UNPLUG    = 8'h06;
  localparam byte_t ADDR_UNPLUG_C  = 8'h07;
  localparam byte_t ADDR_LIMIT     = 8'h08;
  localparam byte_t ADDR_LIMIT_C   = 8'h09;
  localparam byte_t ADDR_SUPPLY    = 8'h0A;
  localparam byte_t ADDR_SUPPLY_C  = 8'h0B;
  localparam byte_t ADDR_TURNON    = 8'h24;
  localparam byte_t ADDR_TURNON_C  = 8'h25;

  // reset values
  localparam byte_t MASK_RESET  = 8'h80;
  localparam byte_t EVREG_RESET = 8'h00;
  localparam byte_t RDATA_NONE  = 8'h00;

  // event register indices inside a bank
  localparam evidx_t EV_POWER  = 3'h0;
  localparam evidx_t EV_PROBE  = 3'h1;
  localparam evidx_t EV_UNPLUG = 3'h2;
  localparam evidx_t EV_LIMIT  = 3'h3;
  localparam evidx_t EV_SUPPLY = 3'h4;
  localparam evidx_t EV_TURNON = 3'h5;

  // summary bit positions, also the mask bit positions
  localparam int SUM_SUPPLY  = 7;
  localparam int SUM_START   = 6;
  localparam int SUM_PIFAULT = 5;
  localparam int SUM_CLASS   = 4;
  localparam int SUM_DETECT  = 3;
  localparam int SUM_DISC    = 2;
  localparam int SUM_PGOOD   = 1;
  localparam int SUM_PENABLE = 0;

  // supply_events fields; bit 0 is reserved and reads zero
  localparam int    SUP_OSS     = 1;
  localparam int    SUP_PCUT_LO = 2;
  localparam int    SUP_PCUT_HI = 3;
  localparam byte_t SUP_USED    = 8'hFE;

  typedef struct packed {
    logic   hit;
    logic   clr;
    evidx_t idx;
  } evsel_s;

  function automatic logic [NIB-1:0] hi_nib(input byte_t v);
    return v[NIB +: NIB];
  endfunction : hi_nib

  function automatic logic [NIB-1:0] lo_nib(input byte_t v);
    return v[0 +: NIB];
  endfunction : lo_nib

  // maps an address onto an event register and its view
  function automatic evsel_s decode_event(input byte_t addr);
    evsel_s s;
    s = '{hit: 1'b1, clr: 1'b0, idx: EV_POWER};
    case (addr)
      ADDR_POWER:    s = '{1'b1, 1'b0, EV_POWER};
      ADDR_POWER_C:  s = '{1'b1, 1'b1, EV_POWER};
      ADDR_PROBE:    s = '{1'b1, 1'b0, EV_PROBE};
      ADDR_PROBE_C:  s = '{1'b1, 1'b1, EV_PROBE};
      ADDR_UNPLUG:   s = '{1'b1, 1'b0, EV_UNPLUG};
      ADDR_UNPLUG_C: s = '{1'b1, 1'b1, EV_UNPLUG};
      ADDR_LIMIT:    s = '{1'b1, 1'b0, EV_LIMIT};
      ADDR_LIMIT_C:  s = '{1'b1, 1'b1, EV_LIMIT};
      ADDR_SUPPLY:   s = '{1'b1, 1'b0, EV_SUPPLY};
      ADDR_SUPPLY_C: s = '{1'b1, 1'b1, EV_SUPPLY};
      ADDR_TURNON:   s = '{1'b1, 1'b0, EV_TURNON};
      ADDR_TURNON_C: s = '{1'b1, 1'b1, EV_TURNON};
      default:       s = '{1'b0, 1'b0, EV_POWER};
    endcase
    return s;
  endfunction : decode_event

endpackage : pse_irq_pkg

//--- core/event_flag_bank.sv
// sticky event flag registers of one port group
`timescale 1ns/1ps
`default_nettype none
module event_flag_bank (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // per-bit set and clear requests
  input  wire pse_irq_pkg::evbank_t set_bits,
  input  wire pse_irq_pkg::evbank_t clr_bits,
  // stored flags
  output pse_irq_pkg::evbank_t      flags
);
  import pse_irq_pkg::*;

  // set beats clear so an event landing on a clear is never lost
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      for (int i = 0; i < NUM_EVREGS; i++) begin
        if (evidx_t'(i) == EV_SUPPLY) begin
          flags[i] <= ((flags[i] & ~clr_bits[i]) | set_bits[i]) & SUP_USED;
        end else begin
          flags[i] <= (flags[i] & ~clr_bits[i]) | set_bits[i];
        end
      end
    end
  end

endmodule : event_flag_bank
`default_nettype wire

//--- core/port_event_interrupt_aggregator.sv
// event flags, summaries, masks and interrupt pin of both port groups
`timescale 1ns/1ps
`default_nettype none
module port_event_interrupt_aggregator (
  // clock and reset
  input  wire logic                              SYS_CLK,
  input  wire logic                              RSTN,
  // register access
  input  wire logic                              REG_GROUP,
  input  wire logic                              REG_RD_EN,
  input  wire logic                              REG_WR_EN,
  input  wire pse_irq_pkg::byte_t                REG_ADDR,
  input  wire pse_irq_pkg::byte_t                REG_WDATA,
  output pse_irq_pkg::byte_t                     REG_RDATA,
  output logic                                   REG_RVALID,
  // event set pulses, group 1 in the upper byte
  input  wire logic [pse_irq_pkg::EV_BUS_W-1:0]  POWER_CHANGE_SET,
  input  wire logic [pse_irq_pkg::EV_BUS_W-1:0]  PROBE_DONE_SET,
  input  wire logic [pse_irq_pkg::EV_BUS_W-1:0]  UNPLUG_OVERPOWER_SET,
  input  wire logic [pse_irq_pkg::EV_BUS_W-1:0]  LIMIT_STARTUP_SET,
  input  wire logic [pse_irq_pkg::EV_BUS_W-1:0]  SUPPLY_SET,
  input  wire logic [pse_irq_pkg::EV_BUS_W-1:0]  TURN_ON_FAULT_SET,
  // per-port commands
  input  wire logic [pse_irq_pkg::NUM_PORTS-1:0] PORT_SHUTDOWN_MODE,
  input  wire logic [pse_irq_pkg::NUM_PORTS-1:0] PORT_POWER_OFF_CMD,
  input  wire logic [pse_irq_pkg::NUM_PORTS-1:0] PORT_RESET_CMD,
  // per-group commands and the shared clear-pin command
  input  wire logic [pse_irq_pkg::NUM_GROUPS-1:0] GROUP_RESET,
  input  wire logic [pse_irq_pkg::NUM_GROUPS-1:0] WIPE_ALL_EVENTS_CMD,
  input  wire logic [pse_irq_pkg::NUM_GROUPS-1:0] EMERGENCY_OFF,
  input  wire logic                              CLEAR_PIN_CMD,
  // interrupt pin
  output logic                                   IRQ_PIN_N
);
  import pse_irq_pkg::*;

  evbank_t                   set_v   [NUM_GROUPS];
  evbank_t                   clr_v   [NUM_GROUPS];
  evbank_t                   flags   [NUM_GROUPS];
  byte_t                     summary [NUM_GROUPS];
  byte_t                     mask    [NUM_GROUPS];
  byte_t                     enabled [NUM_GROUPS];
  byte_t                     enabled_prev [NUM_GROUPS];
  logic [NUM_GROUPS-1:0]     grp_req;
  logic [NUM_GROUPS-1:0]     grp_new;
  logic                      any_req;
  logic                      new_req;
  logic                      released;
  logic                      next_released;
  evsel_s                    sel;
  logic                      cor_read;

  assign sel      = decode_event(REG_ADDR);
  assign cor_read = REG_RD_EN && sel.hit && sel.clr;

  // per group: set and clear masks, flag bank, summary, request
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : grp
    localparam int BL = g * BYTE_W;
    localparam int PL = g * PORTS_PER_GROUP;
    logic [NIB-1:0] port_clr;
    logic           full_clr;

    // emergency off wipes every port of the group like a port command
    assign port_clr = PORT_SHUTDOWN_MODE[PL +: NIB]
                    | PORT_POWER_OFF_CMD[PL +: NIB]
                    | PORT_RESET_CMD[PL +: NIB]
                    | {NIB{EMERGENCY_OFF[g]}};
    assign full_clr = GROUP_RESET[g] | WIPE_ALL_EVENTS_CMD[g];

    // set sources; emergency off also raises its own flag
    always_comb begin
      set_v[g]            = '0;
      set_v[g][EV_POWER]  = POWER_CHANGE_SET[BL +: BYTE_W];
      set_v[g][EV_PROBE]  = PROBE_DONE_SET[BL +: BYTE_W];
      set_v[g][EV_UNPLUG] = UNPLUG_OVERPOWER_SET[BL +: BYTE_W];
      set_v[g][EV_LIMIT]  = LIMIT_STARTUP_SET[BL +: BYTE_W];
      set_v[g][EV_SUPPLY] = SUPPLY_SET[BL +: BYTE_W]
                          | (byte_t'(EMERGENCY_OFF[g]) << SUP_OSS);
      set_v[g][EV_TURNON] = TURN_ON_FAULT_SET[BL +: BYTE_W];
    end

    // clear sources: port commands, group wipes, clear-on-read
    always_comb begin
      clr_v[g]            = '0;
      clr_v[g][EV_PROBE]  = {port_clr, port_clr};
      clr_v[g][EV_UNPLUG] = {port_clr, port_clr};
      clr_v[g][EV_LIMIT]  = {port_clr, port_clr};
      clr_v[g][EV_SUPPLY][SUP_PCUT_LO] = port_clr[0] | port_clr[1];
      clr_v[g][EV_SUPPLY][SUP_PCUT_HI] = port_clr[2] | port_clr[3];
      if (full_clr) begin
        clr_v[g] = '1;
      end
      // only the bits returned are cleared; set still wins in the bank
      if (cor_read && REG_GROUP == 1'(g)) begin
        clr_v[g][sel.idx] = clr_v[g][sel.idx] | flags[g][sel.idx];
      end
    end

    event_flag_bank u_bank (
      .clk      (SYS_CLK),
      .rst_n    (RSTN),
      .set_bits (set_v[g]),
      .clr_bits (clr_v[g]),
      .flags    (flags[g])
    );

    // summary bits follow the flags with no storage of their own
    always_comb begin
      summary[g] = '0;
      summary[g][SUM_SUPPLY]  = |hi_nib(flags[g][EV_SUPPLY]);
      summary[g][SUM_START]   = |lo_nib(flags[g][EV_LIMIT]);
      summary[g][SUM_PIFAULT] = |hi_nib(flags[g][EV_LIMIT])
                              | |lo_nib(flags[g][EV_UNPLUG])
                              | flags[g][EV_SUPPLY][SUP_PCUT_LO]
                              | flags[g][EV_SUPPLY][SUP_PCUT_HI];
      summary[g][SUM_CLASS]   = |hi_nib(flags[g][EV_PROBE]);
      summary[g][SUM_DETECT]  = |lo_nib(flags[g][EV_PROBE]);
      summary[g][SUM_DISC]    = |hi_nib(flags[g][EV_UNPLUG])
                              | flags[g][EV_SUPPLY][SUP_OSS];
      summary[g][SUM_PGOOD]   = |hi_nib(flags[g][EV_POWER]);
      summary[g][SUM_PENABLE] = |lo_nib(flags[g][EV_POWER]);
    end

    // mask register, same bit order as the summary
    always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
        mask[g] <= MASK_RESET;
      end else if (REG_WR_EN && REG_ADDR == ADDR_MASK
                   && REG_GROUP == 1'(g)) begin
        mask[g] <= REG_WDATA;
      end
    end

    assign enabled[g] = summary[g] & mask[g];
    assign grp_req[g] = |enabled[g];
    assign grp_new[g] = |(enabled[g] & ~enabled_prev[g]);

    // remembers which enabled bits were already seen by the pin
    always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
        enabled_prev[g] <= '0;
      end else begin
        enabled_prev[g] <= enabled[g];
      end
    end
  end

  assign any_req = |grp_req;
  assign new_req = |grp_new;

  // a fresh enabled bit re-arms the pin after a clear-pin command
  assign next_released = !new_req && any_req
                       && (CLEAR_PIN_CMD || released);

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      released <= 1'b0;
    end else begin
      released <= next_released;
    end
  end

  // pin is registered so it cannot glitch on the board
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      IRQ_PIN_N <= 1'b1;
    end else begin
      IRQ_PIN_N <= !(any_req && !next_released);
    end
  end

  // register read: one-cycle latency, unmapped reads return zero
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      REG_RDATA  <= RDATA_NONE;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD_EN;
      if (REG_RD_EN) begin
        if (REG_ADDR == ADDR_SUMMARY) begin
          REG_RDATA <= summary[REG_GROUP];
        end else if (REG_ADDR == ADDR_MASK) begin
          REG_RDATA <= mask[REG_GROUP];
        end else if (sel.hit) begin
          REG_RDATA <= flags[REG_GROUP][sel.idx];
        end else begin
          REG_RDATA <= RDATA_NONE;
        end
      end
    end
  end

  // helper state for the checks below
  logic    last_cor;
  logic    last_ro;
  logic    last_grp;
  evidx_t  last_idx;
  byte_t   last_set;
  byte_t   last_val;
  logic    last_quiet;
  logic    clr_cmd_any;

  assign clr_cmd_any = |{PORT_SHUTDOWN_MODE, PORT_POWER_OFF_CMD,
                         PORT_RESET_CMD, GROUP_RESET,
                         WIPE_ALL_EVENTS_CMD, EMERGENCY_OFF};

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      last_cor   <= 1'b0;
      last_ro    <= 1'b0;
      last_grp   <= 1'b0;
      last_idx   <= EV_POWER;
      last_set   <= '0;
      last_val   <= '0;
      last_quiet <= 1'b0;
    end else begin
      last_cor   <= cor_read && !clr_cmd_any;
      last_ro    <= REG_RD_EN && sel.hit && !sel.clr;
      last_grp   <= REG_GROUP;
      last_idx   <= sel.idx;
      last_set   <= set_v[REG_GROUP][sel.idx]
                    & ((sel.idx == EV_SUPPLY) ? SUP_USED : byte_t'('1));
      last_val   <= flags[REG_GROUP][sel.idx];
      last_quiet <= !clr_cmd_any;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  // pin follows the combined enabled requests
  a_pin_asserts: assert property (
    any_req && !next_released |=> !IRQ_PIN_N)
    else $error("pin not driven active for enabled request");

  a_pin_idle: assert property (
    !any_req |=> IRQ_PIN_N)
    else $error("pin active without enabled summary bit");

  a_group_alone: assert property (
    grp_req[1] && !grp_req[0] && !next_released |=> !IRQ_PIN_N)
    else $error("group one could not drive the pin alone");

  a_mask_gate: assert property (
    (summary[0] & mask[0]) == '0 && (summary[1] & mask[1]) == '0
    |=> IRQ_PIN_N)
    else $error("masked summary bits drove the pin");

  a_clear_pin: assert property (
    CLEAR_PIN_CMD && !new_req |=> IRQ_PIN_N)
    else $error("clear-pin command did not release the pin");

  a_clear_pin_keeps: assert property (
    CLEAR_PIN_CMD && !clr_cmd_any && !REG_RD_EN
    |=> (summary[0] & $past(summary[0])) == $past(summary[0])
        && (summary[1] & $past(summary[1])) == $past(summary[1]))
    else $error("clear-pin command dropped summary bits");

  a_cor_clears: assert property (
    last_cor |-> flags[last_grp][last_idx] == last_set)
    else $error("clear-on-read left or lost wrong bits");

  a_ro_no_effect: assert property (
    last_ro && last_quiet
    |-> flags[last_grp][last_idx] == (last_val | last_set))
    else $error("plain read changed the event register");

  a_emerg_disc: assert property (
    EMERGENCY_OFF[0] |=> summary[0][SUM_DISC] ##1 1'b1)
    else $error("emergency off did not set disconnect summary");

  a_start_sum: assert property (
    |lo_nib(LIMIT_STARTUP_SET[BYTE_W-1:0])
    |=> summary[0][SUM_START])
    else $error("start fault did not reach the summary");

  a_pgood_sum: assert property (
    |hi_nib(POWER_CHANGE_SET[BYTE_W-1:0])
    |=> summary[0][SUM_PGOOD])
    else $error("power-good change did not reach the summary");

  a_wipe_group: assert property (
    WIPE_ALL_EVENTS_CMD[0] && set_v[0] == '0 |=> summary[0] == '0)
    else $error("wipe-all left summary bits set");

  a_port_off: assert property (
    PORT_POWER_OFF_CMD[0] && set_v[0] == '0
    |=> !flags[0][EV_PROBE][0] && !flags[0][EV_UNPLUG][NIB]
        && !flags[0][EV_LIMIT][0])
    else $error("port power-off left port flags set");

  a_mask_write: assert property (
    REG_WR_EN && REG_ADDR == ADDR_MASK && !REG_GROUP
    |=> mask[0] == $past(REG_WDATA))
    else $error("mask write not stored");

  // summary sources, read strobe and group separation
  a_supply_sum: assert property (
    |hi_nib(SUPPLY_SET[BYTE_W-1:0]) |=> summary[0][SUM_SUPPLY])
    else $error("supply_events did not reach the summary");

  a_unplug_disc: assert property (
    |hi_nib(UNPLUG_OVERPOWER_SET[BYTE_W-1:0]) |=> summary[0][SUM_DISC])
    else $error("disconnection did not reach the summary");

  a_reset_group: assert property (
    GROUP_RESET[0] && set_v[0] == '0 |=> flags[0] == '0)
    else $error("group reset left event flags set");

  a_mask_write_one: assert property (
    REG_WR_EN && REG_ADDR == ADDR_MASK && REG_GROUP
    |=> mask[1] == $past(REG_WDATA) && mask[0] == $past(mask[0]))
    else $error("group one mask write misplaced");

  a_read_valid: assert property (
    REG_RVALID == $past(REG_RD_EN))
    else $error("read valid not one cycle after the strobe");

  a_supply_spare: assert property (
    !flags[0][EV_SUPPLY][0] && !flags[1][EV_SUPPLY][0])
    else $error("reserved supply bit was set");

  // main scenarios
  c_pin_active: cover property (IRQ_PIN_N ##1 !IRQ_PIN_N);
  c_cor_read: cover property (cor_read && summary[REG_GROUP] != '0);
  c_pin_cleared: cover property (CLEAR_PIN_CMD && any_req ##1 IRQ_PIN_N);
  c_both_groups: cover property (grp_req == '1);
  c_clear_race: cover property (cor_read && set_v[REG_GROUP][sel.idx] != '0);

endmodule : port_event_interrupt_aggregator
`default_nettype wire

//--- verification/irq_host_model.sv
// host model that reaches the block's registers
`timescale 1ns/1ps
`default_nettype none
module irq_host_model (
  // clock
  input  wire logic               clk,
  // register access
  output var logic                grp,
  output var logic                rd_en,
  output var logic                wr_en,
  output var pse_irq_pkg::byte_t  addr,
  output var pse_irq_pkg::byte_t  wdata
);
  import pse_irq_pkg::*;

  // idle bus at time zero
  initial begin
    grp   = 1'b0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    addr  = 8'h00;
    wdata = 8'h00;
  end

  // one access, raised after an edge and held to the taking edge
  task automatic acc(input logic g, input logic w, input byte_t a,
                     input byte_t d);
    @(posedge clk);
    grp   <= g;
    rd_en <= !w;
    wr_en <= w;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    // released lines show the inverse, so a stale value never matches
    addr  <= ~a;
    wdata <= ~d;
  endtask : acc
endmodule : irq_host_model
`default_nettype wire

//--- verification/test_port_event_interrupt_aggregator.sv
// self-checking bench for the interrupt aggregator
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
  n_checks++; \
  if ((a) !== (e)) begin \
    n_mismatch++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, a, e); \
  end \
end
module test_port_event_interrupt_aggregator;
  import pse_irq_pkg::*;
  logic                  sys_clk, rstn, clr_pin, grp, rd_en, wr_en;
  logic                  rvalid, irq_n;
  byte_t                 addr, wdata, rdata, r, s, e_rd;
  logic [EV_BUS_W-1:0]   ev_set [NUM_EVREGS];
  logic [NUM_PORTS-1:0]  pcmd [3];
  logic [NUM_GROUPS-1:0] gcmd [3];
  byte_t                 q [$];
  int                    n_mismatch, n_checks, seed, g, i;
  byte_t ra [NUM_EVREGS] = '{ADDR_POWER, ADDR_PROBE, ADDR_UNPLUG,
                             ADDR_LIMIT, ADDR_SUPPLY, ADDR_TURNON};

  irq_host_model u_irq_host_model (.clk(sys_clk), .grp(grp),
    .rd_en(rd_en), .wr_en(wr_en), .addr(addr), .wdata(wdata));

  port_event_interrupt_aggregator u_port_event_interrupt_aggregator (
    .SYS_CLK(sys_clk), .RSTN(rstn), .REG_GROUP(grp),
    .REG_RD_EN(rd_en), .REG_WR_EN(wr_en), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .POWER_CHANGE_SET(ev_set[EV_POWER]),
    .PROBE_DONE_SET(ev_set[EV_PROBE]),
    .UNPLUG_OVERPOWER_SET(ev_set[EV_UNPLUG]),
    .LIMIT_STARTUP_SET(ev_set[EV_LIMIT]),
    .SUPPLY_SET(ev_set[EV_SUPPLY]),
    .TURN_ON_FAULT_SET(ev_set[EV_TURNON]),
    .PORT_SHUTDOWN_MODE(pcmd[0]), .PORT_POWER_OFF_CMD(pcmd[1]),
    .PORT_RESET_CMD(pcmd[2]), .GROUP_RESET(gcmd[0]),
    .WIPE_ALL_EVENTS_CMD(gcmd[1]), .EMERGENCY_OFF(gcmd[2]),
    .CLEAR_PIN_CMD(clr_pin), .IRQ_PIN_N(irq_n));

  // summary expected from one event register's contents
  function automatic byte_t sumf(input int i, input byte_t v);
    byte_t t;
    t = 8'h00;
    case (i)
      0: begin
        t[SUM_PGOOD]   = |v[7:4];
        t[SUM_PENABLE] = |v[3:0];
      end
      1: begin
        t[SUM_CLASS]  = |v[7:4];
        t[SUM_DETECT] = |v[3:0];
      end
      2: begin
        t[SUM_DISC]    = |v[7:4];
        t[SUM_PIFAULT] = |v[3:0];
      end
      3: begin
        t[SUM_PIFAULT] = |v[7:4];
        t[SUM_START]   = |v[3:0];
      end
      4: begin
        t[SUM_SUPPLY]  = |v[7:4];
        t[SUM_PIFAULT] = |v[3:2];
        t[SUM_DISC]    = v[1];
      end
      default: t = 8'h00;
    endcase
    return t;
  endfunction : sumf

  // a read notes its expected data before the strobe goes out
  task automatic rd(input int gg, input byte_t a, input byte_t e);
    q.push_back(e);
    u_irq_host_model.acc(gg[0], 1'b0, a, 8'h00);
  endtask : rd

  task automatic wr(input int gg, input byte_t a, input byte_t d);
    u_irq_host_model.acc(gg[0], 1'b1, a, d);
  endtask : wr

  // one-cycle set pulse into one group's byte
  task automatic ev(input int i, input int gg, input byte_t v);
    @(posedge sys_clk);
    ev_set[i] <= EV_BUS_W'(v) << (gg * BYTE_W);
    @(posedge sys_clk);
    ev_set[i] <= '0;
  endtask : ev

  // commands 0..2 hit port 0, 3..5 group 0, 6 is clear-pin
  task automatic cmd(input int c);
    @(posedge sys_clk);
    if (c < 3) pcmd[c] <= 8'h01;
    else if (c < 6) gcmd[c-3] <= 2'h1;
    else clr_pin <= 1'b1;
    @(posedge sys_clk);
    pcmd    <= '{default: '0};
    gcmd    <= '{default: '0};
    clr_pin <= 1'b0;
  endtask : cmd

  // pin is registered, so give it room before looking
  task automatic pin(input logic v);
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(irq_n, v)
  endtask : pin

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // read data is only meaningful in the cycle that valid stands
  always @(posedge sys_clk) begin
    if (rvalid === 1'b1) begin
      `CHK(q.size() != 0, 1'b1)
      e_rd = q.pop_front();
      `CHK(rdata, e_rd)
    end
  end

  // watchdog, far beyond the few hundred cycles of the run
  initial begin
    #40000;
    n_mismatch++;
    summarize();
  end

  initial begin
    rstn       = 1'b0;
    clr_pin    = 1'b0;
    ev_set     = '{default: '0};
    pcmd       = '{default: '0};
    gcmd       = '{default: '0};
    seed       = 65741;
    n_mismatch = 0;
    n_checks   = 0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    pin(1'b1);
    for (g = 0; g < NUM_GROUPS; g++) begin
      rd(g, ADDR_MASK, MASK_RESET);
      rd(g, ADDR_SUMMARY, 8'h00);
    end
    wr(0, ADDR_SUMMARY, 8'hFF);
    rd(0, ADDR_SUMMARY, 8'h00);
    rd(1, 8'h0C, RDATA_NONE);
    // mask gating and two independent groups
    wr(0, ADDR_MASK, 8'h00);
    ev(EV_LIMIT, 0, 8'h01);
    pin(1'b1);
    wr(0, ADDR_MASK, 8'h40);
    pin(1'b0);
    rd(0, ADDR_MASK, 8'h40);
    rd(1, ADDR_MASK, MASK_RESET);
    wr(1, ADDR_MASK, MASK_RESET);
    rd(0, ADDR_MASK, 8'h40);
    ev(EV_SUPPLY, 1, 8'h80);
    rd(0, ADDR_LIMIT_C, 8'h01);
    pin(1'b0);
    rd(1, ADDR_SUMMARY, 8'h80);
    rd(1, ADDR_SUPPLY_C, 8'h80);
    pin(1'b1);
    // clear-pin leaves flags and summary alone
    ev(EV_LIMIT, 0, 8'h01);
    pin(1'b0);
    cmd(6);
    pin(1'b1);
    rd(0, ADDR_SUMMARY, 8'h40);
    rd(0, ADDR_LIMIT_C, 8'h01);
    // every event register in both groups, random contents
    for (int k = 0; k < 2 * NUM_EVREGS; k++) begin
      i = k % NUM_EVREGS;
      g = k / NUM_EVREGS;
      r = byte_t'($random(seed));
      ev(i, g, r);
      // the reserved supply bit must not stick
      if (i == EV_SUPPLY) r = r & SUP_USED;
      rd(g, ra[i], r);
      rd(g, ADDR_SUMMARY, sumf(i, r));
      rd(g, ra[i] + 8'h01, r);
      rd(g, ra[i], 8'h00);
      rd(g, ADDR_SUMMARY, 8'h00);
    end
    // each clearing command on port 0's flags and its pair cut bit
    for (int c = 0; c < 6; c++) begin
      ev(EV_PROBE, 0, 8'h11);
      ev(EV_SUPPLY, 0, 8'h0C);
      cmd(c);
      rd(0, ADDR_PROBE, 8'h00);
      s = (c < 3) ? byte_t'(1 << SUP_PCUT_HI) : 8'h00;
      if (c == 5) s = byte_t'(1 << SUP_OSS);
      rd(0, ADDR_SUMMARY, sumf(EV_SUPPLY, s));
      rd(0, ADDR_SUPPLY_C, s);
      rd(0, ADDR_SUMMARY, 8'h00);
    end
    // an event landing with the clearing read survives it
    ev(EV_PROBE, 1, 8'h01);
    fork
      rd(1, ADDR_PROBE_C, 8'h01);
      ev(EV_PROBE, 1, 8'h02);
    join
    rd(1, ADDR_PROBE, 8'h02);
    rd(1, ADDR_PROBE_C, 8'h02);
    repeat (4) @(posedge sys_clk);
    `CHK(q.size(), 0)
    summarize();
  end
endmodule : test_port_event_interrupt_aggregator
`default_nettype wire
